/* File: shared/field_cfg_params.svh */
// constants of the field flag, trim and filter configuration block
`ifndef FIELD_CFG_PARAMS_SVH
`define FIELD_CFG_PARAMS_SVH
`define ADDR_TRIM_AMOUNT 5'h02
`define ADDR_TRIM_ENABLE 5'h03
`define ADDR_THRESH_CFG 5'h06
`define ADDR_FILTER_CFG 5'h0e
`define ADDR_FLAG_STATUS 5'h1b
`define OPC_READ 3'h2
`define OPC_WRITE 3'h4
`define THRESH_CFG_RESET 8'h1d
`define FILTER_CFG_RESET 8'ha0
`define LOW_CODE_MSB 7
`define HIGH_CODE_MSB 4
`define THR_EN_BIT 0
`define FLAG_HIGH_BIT 7
`define FLAG_LOW_BIT 6
`define TICK_NS 1000
`define CLOCK_NS 5
`define TICK_CYCLES (`TICK_NS / `CLOCK_NS)
`define WINDOW_MAX_CODE 4'hc
`define TRIM_FULL 9'h100
`endif

/* File: shared/field_cfg_pkg.sv */
// types of the field flag configuration block
package field_cfg_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_DONE = 2'b10
  } spi_state_t;
endpackage

/* File: rtl/field_comparator.sv */
// hysteretic field strength comparator for one flag
`include "field_cfg_params.svh"
module field_comparator
  import field_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic tick,
  input wire logic enable,
  input wire logic below,
  input wire logic [2:0] code,
  input wire logic [7:0] strength_mt,
  output logic flag
);
  typedef struct packed { logic flag; } cmp_state_t;
  cmp_state_t state_q, state_d;
  logic [7:0] rise_mt, fall_mt;
  // trip points in mT per code, rising and falling edge
  always_comb
  begin
    unique case (code)
      3'h0: rise_mt = 8'h1a;
      3'h1: rise_mt = 8'h29;
      3'h2: rise_mt = 8'h38;
      3'h3: rise_mt = 8'h46;
      3'h4: rise_mt = 8'h54;
      3'h5: rise_mt = 8'h62;
      3'h6: rise_mt = 8'h70;
      3'h7: rise_mt = 8'h7e;
    endcase
    fall_mt = rise_mt - 8'h06;
  end
  // low flag sets under falling point, high flag over rising point
  always_comb
  begin
    state_d = state_q;
    if (!enable)
      state_d.flag = 1'b0;
    else if (tick)
    begin
      if (below)
        state_d.flag = state_q.flag ? (strength_mt < rise_mt) : (strength_mt < fall_mt);
      else
        state_d.flag = state_q.flag ? (strength_mt >= fall_mt) : (strength_mt >= rise_mt);
    end
  end
  always_ff @(posedge clock)
  begin
    if (!rstn)
      state_q <= '0;
    else
      state_q <= state_d;
  end
  assign flag = state_q.flag;
endmodule

/* File: rtl/angle_lowpass.sv */
// first-order low-pass on angle samples
`include "field_cfg_params.svh"
module angle_lowpass
  import field_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic tick,
  input wire logic [3:0] window_code,
  input wire logic [15:0] angle_in,
  output logic [15:0] angle_out
);
  typedef struct packed { logic [31:0] acc; } lp_state_t;
  lp_state_t state_q, state_d;
  logic [3:0] shift;
  logic signed [32:0] diff;
  // tau is 2^shift us with tick 1 us, so alpha is 2^-shift, shift being code capped at 12
  always_comb
  begin
    shift = (window_code > `WINDOW_MAX_CODE) ? `WINDOW_MAX_CODE : window_code;
    diff = $signed({1'b0, angle_in, 16'h0000}) - $signed({1'b0, state_q.acc});
    state_d = state_q;
    if (tick)
      state_d.acc = state_q.acc + 32'(diff >>> shift);
  end
  always_ff @(posedge clock)
  begin
    if (!rstn)
      state_q <= '0;
    else
      state_q <= state_d;
  end
  assign angle_out = state_q.acc[31:16];
endmodule

/* File: rtl/field_flag_trim_filter_config.sv */
// field flag, bias trim and filter configuration with spi register access
`include "field_cfg_params.svh"
module field_flag_trim_filter_config
  import field_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic rstn,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  input wire logic [7:0] field_strength_mt,
  input wire logic [15:0] x_signal,
  input wire logic [15:0] y_signal,
  input wire logic [15:0] angle_raw,
  output logic [15:0] x_trimmed,
  output logic [15:0] y_trimmed,
  output logic [15:0] angle_filtered,
  output logic low_field_flag,
  output logic high_field_flag
);
  typedef struct packed {
    spi_state_t st;
    logic sclk_prev;
    logic [4:0] bit_cnt;
    logic [15:0] rx;
    logic [15:0] tx;
    logic [7:0] resp;
    logic miso;
    logic [7:0] bias_trim_amount;
    logic x_axis_trim_enable;
    logic y_axis_trim_enable;
    logic [7:0] thresh_cfg;
    logic [3:0] filter_window_code;
    logic [7:0] tick_cnt;
    logic tick;
    logic [15:0] x_trimmed;
    logic [15:0] y_trimmed;
    logic [15:0] angle_filtered;
    logic low_field_flag;
    logic high_field_flag;
  } top_state_t;
  top_state_t state_q, state_d;
  logic low_raw, high_raw;
  logic [15:0] lp_out;
  logic [8:0] gain;
  logic [24:0] x_prod, y_prod;
  logic [7:0] flag_status;
  logic [7:0] read_data;
  logic [2:0] opcode;
  logic [4:0] addr;

  // low flag: enabled by threshold enable, low code
  field_comparator u_low
  (
    .clock(clock),
    .rstn(rstn),
    .tick(state_q.tick),
    .enable(state_q.thresh_cfg[`THR_EN_BIT]),
    .below(1'b1),
    .code(state_q.thresh_cfg[`LOW_CODE_MSB -: 3]),
    .strength_mt(field_strength_mt),
    .flag(low_raw)
  );

  // high flag uses the high code independently of the low one
  field_comparator u_high
  (
    .clock(clock),
    .rstn(rstn),
    .tick(state_q.tick),
    .enable(state_q.thresh_cfg[`THR_EN_BIT]),
    .below(1'b0),
    .code(state_q.thresh_cfg[`HIGH_CODE_MSB -: 3]),
    .strength_mt(field_strength_mt),
    .flag(high_raw)
  );

  // angle smoothing driven by window code
  angle_lowpass u_lp
  (
    .clock(clock),
    .rstn(rstn),
    .tick(state_q.tick),
    .window_code(state_q.filter_window_code),
    .angle_in(angle_raw),
    .angle_out(lp_out)
  );

  // status byte and register read mux
  always_comb
  begin
    flag_status = 8'h00;
    flag_status[`FLAG_HIGH_BIT] = state_q.high_field_flag;
    flag_status[`FLAG_LOW_BIT] = state_q.low_field_flag;
    opcode = state_q.rx[15:13];
    addr = state_q.rx[12:8];
    unique case (addr)
      `ADDR_TRIM_AMOUNT: read_data = state_q.bias_trim_amount;
      `ADDR_TRIM_ENABLE: read_data = {6'h00, state_q.y_axis_trim_enable, state_q.x_axis_trim_enable};
      `ADDR_THRESH_CFG: read_data = state_q.thresh_cfg;
      `ADDR_FILTER_CFG: read_data = {state_q.filter_window_code, 4'h0};
      `ADDR_FLAG_STATUS: read_data = flag_status;
      default: read_data = 8'h00;
    endcase
  end

  // trim gain: (256 - amount)/256 on selected axes only
  always_comb
  begin
    gain = `TRIM_FULL - {1'b0, state_q.bias_trim_amount};
    x_prod = {9'h000, x_signal} * (state_q.x_axis_trim_enable ? gain : `TRIM_FULL);
    y_prod = {9'h000, y_signal} * (state_q.y_axis_trim_enable ? gain : `TRIM_FULL);
  end

  // spi mode 0 slave, sample tick divider, registered outputs
  always_comb
  begin
    state_d = state_q;
    state_d.sclk_prev = sclk;
    state_d.tick = 1'b0;
    if (state_q.tick_cnt == 8'(`TICK_CYCLES - 1))
    begin
      state_d.tick_cnt = 8'h00;
      state_d.tick = 1'b1;
    end
    else
      state_d.tick_cnt = state_q.tick_cnt + 8'h01;
    if (cs_n)
    begin
      state_d.st = ST_IDLE;
      state_d.bit_cnt = 5'h00;
      state_d.miso = 1'b0;
    end
    else
    begin
      unique case (state_q.st)
        ST_IDLE:
        begin
          state_d.st = ST_SHIFT;
          state_d.tx = {state_q.resp, 8'h00};
          state_d.miso = state_q.resp[7];
        end
        ST_SHIFT:
        begin
          if (sclk && !state_q.sclk_prev)
          begin
            state_d.rx = {state_q.rx[14:0], mosi};
            state_d.bit_cnt = state_q.bit_cnt + 5'h01;
            if (state_q.bit_cnt == 5'h0f)
              state_d.st = ST_DONE;
          end
          else if (!sclk && state_q.sclk_prev)
          begin
            state_d.tx = {state_q.tx[14:0], 1'b0};
            state_d.miso = state_q.tx[14];
          end
        end
        ST_DONE:
        begin
          // act once per frame, then wait here until select rises
          if (state_q.bit_cnt == 5'h10)
          begin
            state_d.bit_cnt = 5'h00;
            if (opcode == `OPC_READ)
              state_d.resp = read_data;
            else if (opcode == `OPC_WRITE)
            begin
              // echo the written byte, refused addresses answer zero
              state_d.resp = state_q.rx[7:0];
              unique case (addr)
                `ADDR_TRIM_AMOUNT: state_d.bias_trim_amount = state_q.rx[7:0];
                `ADDR_TRIM_ENABLE:
                begin
                  state_d.x_axis_trim_enable = state_q.rx[0];
                  state_d.y_axis_trim_enable = state_q.rx[1];
                end
                `ADDR_THRESH_CFG: state_d.thresh_cfg = {state_q.rx[7:2], 1'b0, state_q.rx[0]};
                `ADDR_FILTER_CFG: state_d.filter_window_code = state_q.rx[7:4];
                default: state_d.resp = 8'h00;
              endcase
            end
            else
              state_d.resp = 8'h00;
          end
        end
        default: state_d.st = ST_IDLE;
      endcase
    end
    // registered copies of trim, filter and flag results
    state_d.x_trimmed = x_prod[23:8];
    state_d.y_trimmed = y_prod[23:8];
    state_d.angle_filtered = lp_out;
    state_d.low_field_flag = low_raw;
    state_d.high_field_flag = high_raw;
  end

  // state register; configuration fields come up at their defaults
  always_ff @(posedge clock)
  begin
    if (!rstn)
    begin
      state_q <= '0;
      state_q.thresh_cfg <= `THRESH_CFG_RESET;
      state_q.filter_window_code <= 4'(`FILTER_CFG_RESET >> 4);
    end
    else
      state_q <= state_d;
  end

  // outputs straight from the state register
  assign miso = state_q.miso;
  assign x_trimmed = state_q.x_trimmed;
  assign y_trimmed = state_q.y_trimmed;
  assign angle_filtered = state_q.angle_filtered;
  assign low_field_flag = state_q.low_field_flag;
  assign high_field_flag = state_q.high_field_flag;

  // checks
  property p_flags_off;
    @(posedge clock) disable iff (!rstn)
    !state_q.thresh_cfg[`THR_EN_BIT] |-> ##2 (!low_field_flag && !high_field_flag);
  endproperty
  a_flags_off: assert property (p_flags_off) else $error("flag set while disabled");
  property p_status_bits;
    @(posedge clock) disable iff (!rstn)
    flag_status[7:6] == {high_field_flag, low_field_flag} && flag_status[5:0] == 6'h00;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status layout wrong");
  property p_pin_follows;
    @(posedge clock) disable iff (!rstn)
    ##1 low_field_flag == $past(low_raw);
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("low pin lags");
  property p_high_follows;
    @(posedge clock) disable iff (!rstn)
    ##1 high_field_flag == $past(high_raw);
  endproperty
  a_high_follows: assert property (p_high_follows) else $error("high pin lags");
  // trim checks skip the edge of reset release, when outputs are still cleared
  property p_x_untrim;
    @(posedge clock) disable iff (!rstn)
    rstn && !state_q.x_axis_trim_enable |=> x_trimmed == $past(x_signal);
  endproperty
  a_x_untrim: assert property (p_x_untrim) else $error("x trimmed while off");
  property p_y_untrim;
    @(posedge clock) disable iff (!rstn)
    rstn && !state_q.y_axis_trim_enable |=> y_trimmed == $past(y_signal);
  endproperty
  a_y_untrim: assert property (p_y_untrim) else $error("y trimmed while off");
  property p_equal_trim;
    @(posedge clock) disable iff (!rstn)
    (state_q.x_axis_trim_enable && state_q.y_axis_trim_enable && x_signal == y_signal) |=> x_trimmed == y_trimmed;
  endproperty
  a_equal_trim: assert property (p_equal_trim) else $error("axes trimmed unequally");
  property p_zero_trim;
    @(posedge clock) disable iff (!rstn)
    rstn && state_q.bias_trim_amount == 8'h00 |=> x_trimmed == $past(x_signal);
  endproperty
  a_zero_trim: assert property (p_zero_trim) else $error("zero trim changed x");
  // spi frame, register write and read, and sample tick checks
  property p_miso_idle;
    @(posedge clock) disable iff (!rstn)
    cs_n |=> !miso;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso driven while deselected");
  property p_frame_abort;
    @(posedge clock) disable iff (!rstn)
    cs_n |=> state_q.st == ST_IDLE;
  endproperty
  a_frame_abort: assert property (p_frame_abort) else $error("frame kept after deselect");
  property p_thresh_write;
    @(posedge clock) disable iff (!rstn)
    (state_q.st == ST_DONE && state_q.bit_cnt == 5'h10 && !cs_n && opcode == `OPC_WRITE
      && addr == `ADDR_THRESH_CFG) |=> state_q.thresh_cfg == {$past(state_q.rx[7:2]), 1'b0, $past(state_q.rx[0])};
  endproperty
  a_thresh_write: assert property (p_thresh_write) else $error("threshold codes not kept");
  property p_enable_write;
    @(posedge clock) disable iff (!rstn)
    (state_q.st == ST_DONE && state_q.bit_cnt == 5'h10 && !cs_n && opcode == `OPC_WRITE
      && addr == `ADDR_TRIM_ENABLE) |=> {state_q.y_axis_trim_enable, state_q.x_axis_trim_enable} == $past(state_q.rx[1:0]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("trim enables not kept");
  property p_read_resp;
    @(posedge clock) disable iff (!rstn)
    (state_q.st == ST_DONE && state_q.bit_cnt == 5'h10 && !cs_n && opcode == `OPC_READ
      && addr == `ADDR_FLAG_STATUS) |=> state_q.resp == {$past(high_field_flag), $past(low_field_flag), 6'h00};
  endproperty
  a_read_resp: assert property (p_read_resp) else $error("status read wrong");
  property p_tick_period;
    @(posedge clock) disable iff (!rstn)
    state_q.tick |=> !state_q.tick [*8];
  endproperty
  a_tick_period: assert property (p_tick_period) else $error("tick too fast");
  property p_tick_spacing;
    @(posedge clock) disable iff (!rstn)
    state_q.tick |-> ##200 state_q.tick;
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("tick period wrong");
  // main scenarios
  c_clamp: cover property (@(posedge clock) state_q.filter_window_code > `WINDOW_MAX_CODE);
  c_read: cover property (@(posedge clock) state_q.st == ST_DONE && opcode == `OPC_READ);
  c_write: cover property (@(posedge clock) state_q.st == ST_DONE && opcode == `OPC_WRITE);
  c_high: cover property (@(posedge clock) high_field_flag);
  c_low: cover property (@(posedge clock) low_field_flag);
endmodule

/* File: bench/spi_host_model.sv */
// spi host model: mode 0 frames of sixteen bits, msb first
module spi_host_model (
  input wire logic clock,
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus: select high, clock stands low, data line at its pull-down level
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // one whole frame; each level held four clocks so the block sees every edge
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(posedge clock);
    cs_n <= 1'b0;
    repeat (4) @(posedge clock);
    for (int i = 15; i >= 0; i--)
    begin
      mosi <= tx[i];
      repeat (4) @(posedge clock);
      sclk <= 1'b1;
      repeat (3) @(posedge clock);
      @(negedge clock);
      rx[i] = miso;
      @(posedge clock);
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clock);
    cs_n <= 1'b1;
    mosi <= 1'b0;
    repeat (4) @(posedge clock);
  endtask
endmodule

/* File: bench/tb_top.sv */
// testbench: spi register access, trim, field flag and filter checks
`include "field_cfg_params.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, rstn, cs_n, sclk, mosi, miso, low_field_flag, high_field_flag;
  logic [7:0] field_strength_mt;
  logic [15:0] x_signal, y_signal, angle_raw, x_trimmed, y_trimmed, angle_filtered;
  int err_count = 0;
  int checks = 0;
  int rise [8] = '{26, 41, 56, 70, 84, 98, 112, 126};
  int off [5] = '{-7, -1, 0, -6, -7};
  logic [4:0] lo = 5'h13;
  logic [7:0] tv [3] = '{8'h00, 8'h81, 8'hff};
  logic [31:0] p;

  spi_host_model host_u (.clock(clock), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));

  field_flag_trim_filter_config dut_u (.clock(clock), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
    .miso(miso), .field_strength_mt(field_strength_mt), .x_signal(x_signal), .y_signal(y_signal),
    .angle_raw(angle_raw), .x_trimmed(x_trimmed), .y_trimmed(y_trimmed), .angle_filtered(angle_filtered),
    .low_field_flag(low_field_flag), .high_field_flag(high_field_flag));

  // clock at 200 MHz
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // read: command frame, then the answer arrives in the upper byte of the next
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [15:0] r;
    host_u.xfer({`OPC_READ, a, 8'h00}, r);
    host_u.xfer(16'h0000, r);
    chk(r, {e, 8'h00});
  endtask

  // write, then check the echo in the following frame
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [7:0] e);
    logic [15:0] r;
    host_u.xfer({`OPC_WRITE, a, d}, r);
    host_u.xfer(16'h0000, r);
    chk(r, {e, 8'h00});
  endtask

  task automatic wt(input int n);
    repeat (n * `TICK_CYCLES) @(posedge clock);
  endtask

  task automatic tally_and_finish();
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial
  begin
    repeat (90000) @(posedge clock);
    err_count++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    rstn = 1'b0;
    field_strength_mt = 8'h32;
    x_signal = 16'hfff0;
    y_signal = 16'h1234;
    angle_raw = 16'h0000;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    rd(`ADDR_THRESH_CFG, 8'h1d);
    rd(`ADDR_FILTER_CFG, 8'ha0);
    rd(`ADDR_TRIM_AMOUNT, 8'h00);
    rd(`ADDR_TRIM_ENABLE, 8'h00);
    rd(5'h01, 8'h00);
    wr(5'h01, 8'h5a, 8'h00);
    rd(5'h01, 8'h00);
    // trim amounts 0x00, 0x81 and 0xff, every enable pair
    for (int t = 0; t < 3; t++)
    begin
      wr(`ADDR_TRIM_AMOUNT, tv[t], tv[t]);
      for (int e = 0; e < 4; e++)
      begin
        wr(`ADDR_TRIM_ENABLE, 8'(e), 8'(e));
        p = x_signal * (32'h0000_0100 - 32'(tv[t]));
        chk(x_trimmed, e[0] ? p[23:8] : x_signal);
        p = y_signal * (32'h0000_0100 - 32'(tv[t]));
        chk(y_trimmed, e[1] ? p[23:8] : y_signal);
      end
    end
    // both axes enabled and fed alike come out alike
    @(posedge clock) y_signal <= x_signal;
    repeat (3) @(posedge clock);
    p = x_signal * (32'h0000_0100 - 32'(tv[2]));
    chk(y_trimmed, p[23:8]);
    // every threshold code, rising and falling points on both flags
    for (int c = 0; c < 8; c++)
    begin
      wr(`ADDR_THRESH_CFG, {c[2:0], c[2:0], 2'h1}, {c[2:0], c[2:0], 2'h1});
      for (int s = 0; s < 5; s++)
      begin
        @(posedge clock) field_strength_mt <= 8'(rise[c] + off[s]);
        wt(2);
        chk({14'h0000, low_field_flag, high_field_flag}, {14'h0000, lo[s], ~lo[s]});
        rd(`ADDR_FLAG_STATUS, {~lo[s], lo[s], 6'h00});
      end
    end
    // low code above high code is kept as written
    wr(`ADDR_THRESH_CFG, 8'he1, 8'he1);
    @(posedge clock) field_strength_mt <= 8'h32;
    wt(2);
    chk({14'h0000, low_field_flag, high_field_flag}, 16'h0003);
    rd(`ADDR_FLAG_STATUS, 8'hc0);
    wr(`ADDR_THRESH_CFG, 8'he0, 8'he0);
    chk({14'h0000, low_field_flag, high_field_flag}, 16'h0000);
    rd(`ADDR_FLAG_STATUS, 8'h00);
    // fastest window follows the input, clamped slowest barely moves
    wr(`ADDR_FILTER_CFG, 8'h00, 8'h00);
    @(posedge clock) angle_raw <= 16'h4000;
    wt(4);
    chk(angle_filtered, 16'h4000);
    wr(`ADDR_FILTER_CFG, 8'hf0, 8'hf0);
    @(posedge clock) angle_raw <= 16'hc000;
    wt(3);
    chk({15'h0000, angle_filtered > 16'h400e && angle_filtered < 16'h4018}, 16'h0001);
    tally_and_finish();
  end
endmodule
